/* File: src/spsel_top.sv */
// Purpose: status output pin select for three digital pins
// Assumes: fifo and power signals are on clk_in; chip select and serial data come from pins
// Notes: pin b output enable low means the pin floats
// How it works
// - three pins, each driven by the signal its own 6-bit select field picks
// - pin b shows its selection only while chip select is high, else serial data
// - pin b floats after reset
// - pin a gives crystal clock divided by 192 after reset
// - writing 0x80 to pin a config routes temperature sensor to pin a
// - in sleep with select below 0x20, pins a and c take polarity, b its complement
// - forced sleep levels hold until core ready goes low
// - select 0x20 or above keeps working in sleep
// - pin b select 0x2e floats the pin while chip select is high; while it is low, serial data drives the pin
// - select 0x00 follows receive fifo at or above threshold
// - select 0x01 sets on threshold or end of packet, clears on receive empty
// - select 0x02 follows transmit fifo at or above threshold
// - select 0x03 sets on transmit full, clears below threshold
// - select 0x04 sets on receive overflow, clears on receive flush
// - select 0x05 sets on transmit underflow, clears on transmit flush
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "spsel_defines.svh"
module spsel_top (
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic [5:0]         wb_adr_in,
	input  wire logic [31:0]        wb_dat_in,
	input  wire logic [3:0]         wb_sel_in,
	input  wire logic               wb_we_in,
	input  wire logic               wb_cyc_in,
	input  wire logic               wb_stb_in,
	output logic      [31:0]        wb_dat_out,
	output logic                    wb_ack_out,
	output logic                    irq_out,
	input  wire spsel_pkg::spsel_fifo_t fifo_in,
	input  wire logic               sleep_in,
	input  wire logic               core_ready_n_in,
	input  wire logic               chip_select_n_in,
	input  wire logic               serial_data_in,
	output logic                    out_pin_a_out,
	output logic                    out_pin_a_oe_out,
	output logic                    temp_sensor_en_out,
	output logic                    out_pin_b_out,
	output logic                    out_pin_b_oe_out,
	output logic                    out_pin_c_out,
	output logic                    out_pin_c_oe_out
);
	logic [7:0] pin_a_config;
	logic [7:0] pin_b_config;
	logic [7:0] pin_c_config;
	logic [5:0] irq_stat;
	logic [5:0] irq_mask;
	logic       rx_pkt_q;
	logic       tx_full_q;
	logic       rx_ovf_q;
	logic       tx_unf_q;
	logic [7:0] div_cnt;
	logic       div_clk;
	logic [1:0] cs_sync;
	logic [1:0] sd_sync;
	logic       wake_seen;
	spsel_pkg::spsel_power_t power_state;
	spsel_pkg::spsel_power_t next_power_state;

	// bus decode; one-cycle registered ack, one wait state
	wire        bus_req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	wire        bus_wr    = bus_req & wb_we_in & wb_sel_in[0];
	wire        hit_a     = wb_adr_in == `SPSEL_OFF_CFG_A;
	wire        hit_b     = wb_adr_in == `SPSEL_OFF_CFG_B;
	wire        hit_c     = wb_adr_in == `SPSEL_OFF_CFG_C;
	wire        hit_fs    = wb_adr_in == `SPSEL_OFF_FIFO_STAT;
	wire        hit_is    = wb_adr_in == `SPSEL_OFF_IRQ_STAT;
	wire        hit_im    = wb_adr_in == `SPSEL_OFF_IRQ_MASK;
	wire [5:0]  fifo_view = {tx_unf_q, rx_ovf_q, tx_full_q, fifo_in.tx_at_thr,
		rx_pkt_q, fifo_in.rx_at_thr};
	wire [7:0]  next_rdata = hit_a ? pin_a_config :
		hit_b ? pin_b_config :
		hit_c ? pin_c_config :
		hit_fs ? {2'b00, fifo_view} :
		hit_is ? {2'b00, irq_stat} :
		hit_im ? {2'b00, irq_mask} : 8'h00;

	// sticky event flags
	wire rx_pkt_set  = fifo_in.rx_at_thr | fifo_in.rx_end_pkt;
	wire next_rx_pkt = rx_pkt_set | (rx_pkt_q & ~fifo_in.rx_empty);
	wire next_tx_full = fifo_in.tx_full | (tx_full_q & fifo_in.tx_at_thr);
	wire next_rx_ovf = fifo_in.rx_overflow | (rx_ovf_q & ~fifo_in.rx_flush);
	wire next_tx_unf = fifo_in.tx_underflow | (tx_unf_q & ~fifo_in.tx_flush);
	wire [5:0] irq_set = {fifo_in.tx_underflow, fifo_in.rx_overflow, fifo_in.tx_full,
		1'b0, fifo_in.rx_end_pkt, 1'b0};
	wire [5:0] irq_clr = (bus_wr & hit_is) ? wb_dat_in[5:0] : 6'h00;
	// set wins over a clear landing in the same cycle
	wire [5:0] next_irq_stat = irq_set | (irq_stat & ~irq_clr);
	wire [5:0] next_irq_mask = (bus_wr && hit_im) ? wb_dat_in[5:0] : irq_mask;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pin_a_config <= `SPSEL_RST_CFG_A;
			pin_b_config <= `SPSEL_RST_CFG_B;
			pin_c_config <= `SPSEL_RST_CFG_C;
			irq_mask     <= 6'h00;
			irq_stat     <= 6'h00;
			wb_ack_out   <= 1'b0;
			wb_dat_out   <= 32'h0000_0000;
		end
		else
		begin
			if (bus_wr && hit_a)
				pin_a_config <= wb_dat_in[7:0];
			if (bus_wr && hit_b)
				pin_b_config <= wb_dat_in[7:0];
			if (bus_wr && hit_c)
				pin_c_config <= wb_dat_in[7:0];
			irq_mask   <= next_irq_mask;
			irq_stat   <= next_irq_stat;
			wb_ack_out <= bus_req;
			wb_dat_out <= {24'h00_0000, next_rdata};
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rx_pkt_q  <= 1'b0;
			tx_full_q <= 1'b0;
			rx_ovf_q  <= 1'b0;
			tx_unf_q  <= 1'b0;
			irq_out   <= 1'b0;
		end
		else
		begin
			rx_pkt_q  <= next_rx_pkt;
			tx_full_q <= next_tx_full;
			rx_ovf_q  <= next_rx_ovf;
			tx_unf_q  <= next_tx_unf;
			irq_out   <= |(next_irq_stat & next_irq_mask);
		end
	end

	// crystal clock divider, 50 percent duty
	wire div_wrap = div_cnt == (`SPSEL_CLK_DIV - 8'd1);
	wire div_half = div_cnt == (`SPSEL_CLK_HALF - 8'd1);
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			div_cnt <= 8'h00;
			div_clk <= 1'b0;
		end
		else
		begin
			div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'd1;
			if (div_wrap || div_half)
				div_clk <= ~div_clk;
		end
	end

	// pin synchronisers; first stage read only by second
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cs_sync <= 2'b11;
			sd_sync <= 2'b00;
		end
		else
		begin
			cs_sync <= {cs_sync[0], chip_select_n_in};
			sd_sync <= {sd_sync[0], serial_data_in};
		end
	end
	wire cs_n_s = cs_sync[1];

	// power: forced levels hold after sleep ends until core ready goes low
	always_comb
	begin
		next_power_state = power_state;
		case (power_state)
			spsel_pkg::SPSEL_AWAKE:
				if (sleep_in)
					next_power_state = spsel_pkg::SPSEL_ASLEEP;
			spsel_pkg::SPSEL_ASLEEP:
				if (!sleep_in)
					next_power_state = spsel_pkg::SPSEL_WAKING;
			spsel_pkg::SPSEL_WAKING:
				if (!core_ready_n_in)
					next_power_state = spsel_pkg::SPSEL_AWAKE;
			default:
				next_power_state = spsel_pkg::SPSEL_AWAKE;
		endcase
	end
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			power_state <= spsel_pkg::SPSEL_AWAKE;
		else
			power_state <= next_power_state;
	end
	assign wake_seen = power_state != spsel_pkg::SPSEL_AWAKE;
	wire forced = wake_seen | sleep_in;

	// per-pin source select
	logic [2:0][7:0] cfg;
	logic [2:0]      next_lvl;
	logic [2:0]      next_oe;
	assign cfg = {pin_c_config, pin_b_config, pin_a_config};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_pin
			wire [5:0] sel = cfg[gi][`SPSEL_SEL_MSB:0];
			wire       inv = cfg[gi][`SPSEL_INV_BIT];
			wire       src = (sel == `SPSEL_SEL_RX_THR)  ? fifo_in.rx_at_thr :
				(sel == `SPSEL_SEL_RX_PKT)  ? rx_pkt_q :
				(sel == `SPSEL_SEL_TX_THR)  ? fifo_in.tx_at_thr :
				(sel == `SPSEL_SEL_TX_FULL) ? tx_full_q :
				(sel == `SPSEL_SEL_RX_OVF)  ? rx_ovf_q :
				(sel == `SPSEL_SEL_TX_UNF)  ? tx_unf_q :
				(sel == `SPSEL_SEL_CLK_DIV) ? div_clk : 1'b0;
			wire       low_sel = sel < `SPSEL_SLEEP_LIMIT;
			wire       force_lvl = (gi == 1) ? ~inv : inv;
			wire       hiz = (gi == 1) && (sel == `SPSEL_SEL_HIZ);
			// low codes are forced while asleep; high codes run on
			assign next_lvl[gi] = (forced && low_sel) ? force_lvl : (src ^ inv);
			assign next_oe[gi]  = ~hiz;
		end
	endgenerate

	// pin b is shared with serial read data while selected
	wire temp_on = pin_a_config == `SPSEL_TEMP_CODE;
	wire next_b_lvl = cs_n_s ? next_lvl[1] : sd_sync[1];
	wire next_b_oe  = cs_n_s ? next_oe[1] : 1'b1;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			out_pin_a_out      <= 1'b0;
			out_pin_a_oe_out   <= 1'b1;
			temp_sensor_en_out <= 1'b0;
			out_pin_b_out      <= 1'b0;
			out_pin_b_oe_out   <= 1'b0;
			out_pin_c_out      <= 1'b0;
			out_pin_c_oe_out   <= 1'b1;
		end
		else
		begin
			// analog sensor takes the pin, digital driver released
			out_pin_a_out      <= temp_on ? 1'b0 : next_lvl[0];
			out_pin_a_oe_out   <= ~temp_on;
			temp_sensor_en_out <= temp_on;
			out_pin_b_out      <= next_b_lvl;
			out_pin_b_oe_out   <= next_b_oe;
			out_pin_c_out      <= next_lvl[2];
			out_pin_c_oe_out   <= next_oe[2];
		end
	end

	a_reset_b_float: assert property (@(posedge clk_in)
		$rose(rst_n_in) |-> !out_pin_b_oe_out)
		else $error("pin b drives right after reset");
	a_hiz_b_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(pin_b_config[5:0] == `SPSEL_SEL_HIZ && cs_n_s) |=> !out_pin_b_oe_out)
		else $error("pin b drives with float select");
	a_serial_b_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!cs_n_s |=> (out_pin_b_oe_out && out_pin_b_out == $past(sd_sync[1])))
		else $error("pin b not carrying serial data");
	a_temp_route_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		temp_on |=> (temp_sensor_en_out && !out_pin_a_oe_out))
		else $error("temperature sensor not routed");
	a_sleep_force_c: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(sleep_in && pin_c_config[5:0] < `SPSEL_SLEEP_LIMIT)
		|=> out_pin_c_out == $past(pin_c_config[6]))
		else $error("pin c not forced in sleep");
	a_wake_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(power_state == spsel_pkg::SPSEL_WAKING && core_ready_n_in)
		|=> power_state != spsel_pkg::SPSEL_AWAKE)
		else $error("forced level released before core ready");
	a_ovf_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(rx_ovf_q && !fifo_in.rx_flush) |=> rx_ovf_q)
		else $error("overflow flag dropped without flush");
	a_unf_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		fifo_in.tx_underflow |=> tx_unf_q ##1 (tx_unf_q || $past(fifo_in.tx_flush)))
		else $error("underflow flag lost");
	a_pkt_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(fifo_in.rx_empty && !rx_pkt_set) |=> !rx_pkt_q)
		else $error("packet flag not cleared on empty");
	a_full_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!fifo_in.tx_at_thr && !fifo_in.tx_full) |=> !tx_full_q)
		else $error("full flag not cleared below threshold");
	a_clk_period: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(div_clk) |-> ##96 $fell(div_clk) ##96 $rose(div_clk))
		else $error("divided clock period wrong");
	a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		irq_out == |(irq_stat & irq_mask))
		else $error("interrupt level differs from masked status");
	a_ack_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack held longer than one cycle");
	// the first five pin level checks sit on pin c: no sensor and no serial sharing there
	a_rx_thr_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(pin_c_config[5:0] == `SPSEL_SEL_RX_THR && !forced)
		|=> out_pin_c_out == ($past(fifo_in.rx_at_thr) ^ $past(pin_c_config[6])))
		else $error("pin c not following receive threshold");
	a_pkt_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(pin_c_config[5:0] == `SPSEL_SEL_RX_PKT && !forced)
		|=> out_pin_c_out == ($past(rx_pkt_q) ^ $past(pin_c_config[6])))
		else $error("pin c not showing packet flag");
	a_tx_thr_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(pin_c_config[5:0] == `SPSEL_SEL_TX_THR && !forced)
		|=> out_pin_c_out == ($past(fifo_in.tx_at_thr) ^ $past(pin_c_config[6])))
		else $error("pin c not following transmit threshold");
	a_unf_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(pin_c_config[5:0] == `SPSEL_SEL_TX_UNF && !forced)
		|=> out_pin_c_out == ($past(tx_unf_q) ^ $past(pin_c_config[6])))
		else $error("pin c not showing underflow flag");
	a_undef_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(pin_c_config[5:0] >= `SPSEL_SLEEP_LIMIT && pin_c_config[5:0] != `SPSEL_SEL_CLK_DIV)
		|=> out_pin_c_out == $past(pin_c_config[6]))
		else $error("undefined select not at fixed level");
	a_sleep_force_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(sleep_in && pin_a_config[5:0] < `SPSEL_SLEEP_LIMIT && !temp_on)
		|=> out_pin_a_out == $past(pin_a_config[6]))
		else $error("pin a not forced in sleep");
	a_sleep_force_b: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(sleep_in && cs_n_s && pin_b_config[5:0] < `SPSEL_SLEEP_LIMIT)
		|=> out_pin_b_out == !$past(pin_b_config[6]))
		else $error("pin b not forced to complement in sleep");
	a_sleep_run_c: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(sleep_in && pin_c_config[5:0] == `SPSEL_SEL_CLK_DIV)
		|=> out_pin_c_out == ($past(div_clk) ^ $past(pin_c_config[6])))
		else $error("high select stopped in sleep");
	a_clk_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(pin_a_config[5:0] == `SPSEL_SEL_CLK_DIV && !pin_a_config[6])
		|=> out_pin_a_out == $past(div_clk))
		else $error("pin a not carrying divided clock");
	a_wake_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(power_state == spsel_pkg::SPSEL_WAKING && !core_ready_n_in)
		|=> power_state == spsel_pkg::SPSEL_AWAKE)
		else $error("forced level kept after core ready");
	a_sel_b_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(cs_n_s && pin_b_config[5:0] == `SPSEL_SEL_RX_THR && !forced)
		|=> out_pin_b_out == ($past(fifo_in.rx_at_thr) ^ $past(pin_b_config[6])))
		else $error("pin b not following its select");
	a_sel_a_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(pin_a_config[5:0] == `SPSEL_SEL_TX_THR && !forced)
		|=> out_pin_a_out == ($past(fifo_in.tx_at_thr) ^ $past(pin_a_config[6])))
		else $error("pin a not following its select");
	a_pkt_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_pkt_set |=> rx_pkt_q)
		else $error("packet flag not set");
	a_full_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		fifo_in.tx_full |=> tx_full_q)
		else $error("full flag not set");
	a_ovf_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		fifo_in.rx_overflow |=> rx_ovf_q)
		else $error("overflow flag not set");
	a_drive_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!temp_on |=> out_pin_a_oe_out)
		else $error("pin a released without sensor");
	c_sleep_wake: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		power_state == spsel_pkg::SPSEL_WAKING ##1 power_state == spsel_pkg::SPSEL_AWAKE);
	c_serial_read: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		!cs_n_s ##1 cs_n_s);
	c_ovf_flush: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_ovf_q ##1 !rx_ovf_q);
	c_temp_on: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		temp_sensor_en_out);
	c_unf_flush: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		tx_unf_q ##1 !tx_unf_q);
endmodule : spsel_top
`default_nettype wire

/* File: pkg/spsel_defines.svh */
// Purpose: offsets, field positions, reset values and codes for the pin select block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: definitions only
`ifndef SPSEL_DEFINES_SVH
`define SPSEL_DEFINES_SVH
`define SPSEL_OFF_CFG_A      6'h00
`define SPSEL_OFF_CFG_B      6'h04
`define SPSEL_OFF_CFG_C      6'h08
`define SPSEL_OFF_FIFO_STAT  6'h0c
`define SPSEL_OFF_IRQ_STAT   6'h10
`define SPSEL_OFF_IRQ_MASK   6'h14
`define SPSEL_SEL_MSB        5
`define SPSEL_INV_BIT        6
`define SPSEL_TEMP_BIT       7
`define SPSEL_RST_CFG_A      8'h3f
`define SPSEL_RST_CFG_B      8'h2e
`define SPSEL_RST_CFG_C      8'h29
`define SPSEL_TEMP_CODE      8'h80
`define SPSEL_SEL_RX_THR     6'h00
`define SPSEL_SEL_RX_PKT     6'h01
`define SPSEL_SEL_TX_THR     6'h02
`define SPSEL_SEL_TX_FULL    6'h03
`define SPSEL_SEL_RX_OVF     6'h04
`define SPSEL_SEL_TX_UNF     6'h05
`define SPSEL_SEL_HIZ        6'h2e
`define SPSEL_SEL_CLK_DIV    6'h3f
`define SPSEL_SLEEP_LIMIT    6'h20
`define SPSEL_CLK_DIV        8'd192
`define SPSEL_CLK_HALF       8'd96
`endif

/* File: pkg/spsel_pkg.sv */
// Purpose: types for the pin select block
// Assumes: nothing
// Notes: fifo events travel as one struct
package spsel_pkg;
	typedef struct packed {
		logic rx_at_thr;
		logic rx_end_pkt;
		logic rx_empty;
		logic rx_overflow;
		logic rx_flush;
		logic tx_at_thr;
		logic tx_full;
		logic tx_underflow;
		logic tx_flush;
	} spsel_fifo_t;
	typedef enum logic [1:0] {
		SPSEL_AWAKE   = 2'b00,
		SPSEL_ASLEEP  = 2'b01,
		SPSEL_WAKING  = 2'b10
	} spsel_power_t;
endpackage : spsel_pkg

/* File: test/spsel_host_mon.sv */
// Purpose: host side model watching status pins a and b
// Assumes: pin b sits on a shared serial line with a pull-up
// Notes: measures the pin a clock period in cycles
`timescale 1ns/1ps
`default_nettype none
module spsel_host_mon (
	input  wire logic        clk_in,
	input  wire logic        pin_a_in,
	input  wire logic        pin_b_in,
	input  wire logic        pin_b_oe_in,
	output logic             pin_b_wire_out,
	output logic [15:0]      period_out
);
	logic [15:0] cnt;
	logic        last_a;
	logic        rise;
	// floating line reads high, so a stale driven value never passes
	assign pin_b_wire_out = pin_b_oe_in ? pin_b_in : 1'h1;
	assign rise           = pin_a_in & ~last_a;
	always_ff @(posedge clk_in)
	begin
		last_a <= pin_a_in;
		cnt    <= rise ? 16'h0001 : cnt + 16'h0001;
		if (rise)
			period_out <= cnt;
	end
endmodule : spsel_host_mon
`default_nettype wire

/* File: test/spsel_top_tb_top.sv */
// Purpose: self-checking bench for the pin select block
// Assumes: registers reached by classic wishbone single cycles
// Notes: pin b is read through the host model wire
`timescale 1ns/1ps
`default_nettype none
module spsel_top_tb_top;
	logic        clk, ack, irq, pa, pa_oe, temp, pb, pb_oe, pc, pc_oe, pbw, pc0;
	logic        rst_n = 1'h0, we = 1'h0, cyc = 1'h0, stb = 1'h0, slp = 1'h0;
	logic        core_ready_n = 1'h0, chip_select_n = 1'h1, sdat = 1'h0;
	logic [5:0]  adr = 6'h00;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic [15:0] per;
	int          error_cnt = 0, check_count = 0, cycles = 0, i;
	spsel_pkg::spsel_fifo_t fifo = 9'h000;
	// {select, fifo inputs held, expected pin c}
	logic [15:0] tbl [17] = '{16'h0201, 16'h0000, 16'h0601, 16'h0401, 16'h0480,
		16'h0811, 16'h0800, 16'h0c09, 16'h0c11, 16'h0c00, 16'h1041, 16'h1001,
		16'h1020, 16'h1405, 16'h1401, 16'h1402, 16'h0000};
	spsel_top i_dut (.clk_in(clk), .rst_n_in(rst_n), .wb_adr_in(adr), .wb_dat_in(wdat),
		.wb_sel_in(4'hf), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq), .fifo_in(fifo),
		.sleep_in(slp), .core_ready_n_in(core_ready_n), .chip_select_n_in(chip_select_n),
		.serial_data_in(sdat), .out_pin_a_out(pa), .out_pin_a_oe_out(pa_oe),
		.temp_sensor_en_out(temp), .out_pin_b_out(pb), .out_pin_b_oe_out(pb_oe),
		.out_pin_c_out(pc), .out_pin_c_oe_out(pc_oe));
	spsel_host_mon i_host (.clk_in(clk), .pin_a_in(pa), .pin_b_in(pb),
		.pin_b_oe_in(pb_oe), .pin_b_wire_out(pbw), .period_out(per));
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	task automatic results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	// whole run is under a thousand cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			error_cnt++;
			results();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %0t word %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic chk1(input logic g, input logic e);
		check_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %0t pin %b expected %b", $time, g, e);
		end
	endtask : chk1
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc  <= 1'h1;
		stb  <= 1'h1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do
			@(posedge clk);
		while (ack !== 1'h1);
		rd = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we  <= 1'h0;
	endtask : wb
	// settle past the edge so registered pins are sampled stable
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		wb(1'h0, 6'h00, 32'h0);
		chk(rd, 32'h3f);
		wb(1'h0, 6'h04, 32'h0);
		chk(rd, 32'h2e);
		wb(1'h0, 6'h08, 32'h0);
		chk(rd, 32'h29);
		wb(1'h0, 6'h18, 32'h0);
		chk(rd, 32'h0);
		tick(1);
		chk1(pb_oe, 1'h0);
		chk1(pc, 1'h0);
		chk1(pc_oe, 1'h1);
		tick(400);
		chk({16'h0, per}, 32'hc0);
		chk1(pa_oe, 1'h1);
		$display("reset and clock done");
		for (i = 0; i < 17; i++)
		begin
			wb(1'h1, 6'h08, {26'h0, tbl[i][15:10]});
			fifo <= tbl[i][9:1];
			tick(3);
			chk1(pc, tbl[i][0]);
		end
		wb(1'h1, 6'h08, 32'h40);
		tick(2);
		chk1(pc, 1'h1);
		wb(1'h0, 6'h10, 32'h0);
		chk(rd, 32'h38);
		wb(1'h1, 6'h14, 32'h08);
		tick(2);
		chk1(irq, 1'h1);
		wb(1'h1, 6'h10, 32'h08);
		wb(1'h0, 6'h10, 32'h0);
		chk(rd, 32'h30);
		tick(1);
		chk1(irq, 1'h0);
		$display("select codes and irq done");
		wb(1'h1, 6'h00, 32'h42);
		fifo <= 9'h008;
		wb(1'h1, 6'h04, 32'h40);
		wb(1'h1, 6'h08, 32'h3f);
		tick(3);
		chk1(pa, 1'h0);
		chk1(pbw, 1'h1);
		wb(1'h0, 6'h0c, 32'h0);
		chk(rd, 32'h04);
		@(posedge clk);
		slp <= 1'h1;
		core_ready_n <= 1'h1;
		tick(3);
		chk1(pa, 1'h1);
		chk1(pbw, 1'h0);
		pc0 = pc;
		tick(96);
		chk1(pc, ~pc0);
		@(posedge clk);
		slp <= 1'h0;
		tick(3);
		chk1(pa, 1'h1);
		@(posedge clk);
		core_ready_n <= 1'h0;
		tick(3);
		chk1(pa, 1'h0);
		chk1(pbw, 1'h1);
		wb(1'h1, 6'h04, 32'h2e);
		slp <= 1'h1;
		tick(3);
		chk1(pb_oe, 1'h0);
		$display("sleep done");
		wb(1'h1, 6'h04, 32'h00);
		slp <= 1'h0;
		chip_select_n <= 1'h0;
		tick(4);
		chk1(pb_oe, 1'h1);
		@(posedge clk);
		sdat <= 1'h1;
		tick(4);
		chk1(pbw, 1'h1);
		@(posedge clk);
		chip_select_n <= 1'h1;
		tick(4);
		chk1(pbw, 1'h0);
		wb(1'h1, 6'h00, 32'h80);
		tick(2);
		chk1(temp, 1'h1);
		chk1(pa_oe, 1'h0);
		chk1(pa, 1'h0);
		$display("serial and sensor done");
		results();
	end
endmodule : spsel_top_tb_top
`default_nettype wire
